// ===== logic/crie_map.svh
// Register offsets, field positions, enable reset value and error thresholds
`ifndef CRIE_MAP_SVH
`define CRIE_MAP_SVH
`define CRIE_OFF_ENABLE   4'h0
`define CRIE_OFF_FLAGS    4'h1
`define CRIE_OFF_STATUS   4'h2
`define CRIE_OFF_IRQMASK  4'h3
`define CRIE_BIT_WAKE     7
`define CRIE_BIT_CSC      6
`define CRIE_RXS_HI       5
`define CRIE_RXS_LO       4
`define CRIE_TXS_HI       3
`define CRIE_TXS_LO       2
`define CRIE_BIT_OVR      1
`define CRIE_BIT_RXF      0
`define CRIE_ENABLE_RST   8'h00
`define CRIE_WARN_LIMIT   9'h060
`define CRIE_PASS_LIMIT   9'h07F
`define CRIE_OFF_LIMIT    9'h0FF
`endif

// ===== logic/crie_pkg.sv
// Types shared by the receiver interrupt enable block
package crie_pkg;
  typedef enum logic [1:0] {
    CRIE_ST_OK      = 2'h0,
    CRIE_ST_WARNING = 2'h1,
    CRIE_ST_PASSIVE = 2'h2,
    CRIE_ST_BUSOFF  = 2'h3
  } crie_state_t;
endpackage

// ===== logic/crie_top.sv
// Receiver interrupt enable register, status change logic and requests
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "crie_map.svh"

// Overview of operation
// - Init mode holds enable register reset except the sensitivity fields
// - Enable register writes only outside init mode
// - Sensitivity fields survive init mode
// - Wake enable gates wake request
// - Status change enable gates error request
// - Receiver sensitivity selects flagged transitions
// - Transmitter sensitivity selects flagged transitions
// - State bits update only without pending flag
// - Overrun enable gates error request
// - Receive full enable gates receive request
// - Transmitter bus-off forces receiver bus-off; leaving it restores the receiver counter state
// - Status change flag set on state change
// - Receiver OK up to 96, warning to 127
// - Receive full flag set on buffer load
module crie_top
  import crie_pkg::*;
(
  input  wire logic       core_clk_in,      // Bus clock
  input  wire logic       rst_n_in,         // Synchronous reset, low
  input  wire logic [3:0] addr_in,          // Register address
  input  wire logic [7:0] wdata_in,         // Write data
  input  wire logic       wr_in,            // Write strobe
  input  wire logic       rd_in,            // Read strobe
  output logic      [7:0] rdata_out,        // Read data, cycle after rd
  input  wire logic       init_request_in,  // Init mode requested
  input  wire logic       init_acknowledge_in, // Init mode acknowledged
  input  wire logic       wake_event_in,    // Wake-up event pulse
  input  wire logic       overrun_event_in, // Receive overrun pulse
  input  wire logic       rx_load_in,       // Good frame into foreground
  input  wire logic       rx_release_in,    // Foreground buffer released
  input  wire logic [7:0] rx_err_cnt_in,    // Receive error counter
  input  wire logic [8:0] tx_err_cnt_in,    // Transmit error count
  output logic            wake_irq_out,     // Wake-up request
  output logic            err_irq_out,      // Error request
  output logic            rx_irq_out,       // Receive request
  output logic            irq_out           // Combined masked interrupt
);
  // ==========================================================
  // Registers
  logic [7:0]  en_q, en_d;
  logic        wake_f_q, wake_f_d, csc_f_q, csc_f_d;
  logic        ovr_f_q, ovr_f_d, rxf_f_q, rxf_f_d;
  logic [3:0]  mask_q, mask_d;
  crie_state_t rx_st_q, rx_st_d, tx_st_q, tx_st_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        wake_irq_q, err_irq_q, rx_irq_q, irq_q;
  logic        wake_irq_d, err_irq_d, rx_irq_d, irq_d;

  // ==========================================================
  // Error state decode
  crie_state_t tx_now, rx_now;
  logic        init_mode, init_free, wr_en, wr_fl, wr_mk;
  logic        rx_hit, tx_hit;
  logic [3:0]  flags, clr;

  function automatic logic sens_hit(input logic [1:0] sel,
                                    input crie_state_t o,
                                    input crie_state_t n);
    logic chg;
    chg = (o != n);
    case (sel)
      2'h1: sens_hit = chg && (o == CRIE_ST_BUSOFF || n == CRIE_ST_BUSOFF);
      2'h2: sens_hit = chg && (o[1] != n[1]);
      2'h3: sens_hit = chg;
      default: sens_hit = 1'b0;
    endcase
  endfunction

  always_comb begin
    if (tx_err_cnt_in > `CRIE_OFF_LIMIT)
      tx_now = CRIE_ST_BUSOFF;
    else if (tx_err_cnt_in > `CRIE_PASS_LIMIT)
      tx_now = CRIE_ST_PASSIVE;
    else if (tx_err_cnt_in > `CRIE_WARN_LIMIT)
      tx_now = CRIE_ST_WARNING;
    else
      tx_now = CRIE_ST_OK;
    // Receiver mirrors transmitter bus-off; leaving it gives the state of rx_err_cnt_in
    if (tx_now == CRIE_ST_BUSOFF)
      rx_now = CRIE_ST_BUSOFF;
    else if ({1'b0, rx_err_cnt_in} > `CRIE_PASS_LIMIT)
      rx_now = CRIE_ST_PASSIVE;
    else if ({1'b0, rx_err_cnt_in} > `CRIE_WARN_LIMIT)
      rx_now = CRIE_ST_WARNING;
    else
      rx_now = CRIE_ST_OK;
  end

  // ==========================================================
  // Next state
  always_comb begin
    init_mode = init_request_in && init_acknowledge_in;
    init_free = !init_request_in && !init_acknowledge_in;
    wr_en = wr_in && addr_in == `CRIE_OFF_ENABLE && init_free;
    wr_fl = wr_in && addr_in == `CRIE_OFF_FLAGS;
    wr_mk = wr_in && addr_in == `CRIE_OFF_IRQMASK;
    clr   = wr_fl ? {wdata_in[`CRIE_BIT_WAKE], wdata_in[`CRIE_BIT_CSC],
                     wdata_in[`CRIE_BIT_OVR], wdata_in[`CRIE_BIT_RXF]}
                  : 4'h0;
    en_d = wr_en ? wdata_in : en_q;
    if (init_mode) begin
      // Sensitivity fields keep their value through init mode
      en_d = `CRIE_ENABLE_RST;
      en_d[`CRIE_RXS_HI:`CRIE_RXS_LO] = en_q[`CRIE_RXS_HI:`CRIE_RXS_LO];
      en_d[`CRIE_TXS_HI:`CRIE_TXS_LO] = en_q[`CRIE_TXS_HI:`CRIE_TXS_LO];
    end
    rx_hit = sens_hit(en_q[`CRIE_RXS_HI:`CRIE_RXS_LO], rx_st_q, rx_now);
    tx_hit = sens_hit(en_q[`CRIE_TXS_HI:`CRIE_TXS_LO], tx_st_q, tx_now);
    // State bits are frozen while a status change is pending
    rx_st_d = csc_f_q ? rx_st_q : rx_now;
    tx_st_d = csc_f_q ? tx_st_q : tx_now;
    // Set wins over a clear in the same cycle, except the status change flag, where the clear wins
    wake_f_d = wake_event_in || (wake_f_q && !clr[3]);
    csc_f_d  = (!csc_f_q && (rx_hit || tx_hit))
               || (csc_f_q && !clr[2]);
    ovr_f_d  = overrun_event_in || (ovr_f_q && !clr[1]);
    rxf_f_d  = rx_load_in || (rxf_f_q && !clr[0] && !rx_release_in);
    mask_d   = wr_mk ? wdata_in[3:0] : mask_q;
    flags    = {wake_f_d, csc_f_d, ovr_f_d, rxf_f_d};
    wake_irq_d = wake_f_d && en_d[`CRIE_BIT_WAKE];
    err_irq_d  = (csc_f_d && en_d[`CRIE_BIT_CSC])
                 || (ovr_f_d && en_d[`CRIE_BIT_OVR]);
    rx_irq_d   = rxf_f_d && en_d[`CRIE_BIT_RXF];
    irq_d      = |(flags & mask_d);
    case (addr_in)
      `CRIE_OFF_ENABLE:  rdata_d = en_q;
      `CRIE_OFF_FLAGS:   rdata_d = {wake_f_q, csc_f_q, rx_st_q, tx_st_q,
                                    ovr_f_q, rxf_f_q};
      `CRIE_OFF_STATUS:  rdata_d = {2'h0, rx_st_q, tx_st_q, 2'h0};
      `CRIE_OFF_IRQMASK: rdata_d = {4'h0, mask_q};
      default:           rdata_d = 8'h00;
    endcase
    if (!rd_in)
      rdata_d = 8'h00;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      en_q <= `CRIE_ENABLE_RST;
      wake_f_q <= 1'b0;
      csc_f_q <= 1'b0;
      ovr_f_q <= 1'b0;
      rxf_f_q <= 1'b0;
      mask_q <= 4'h0;
      rx_st_q <= CRIE_ST_OK;
      tx_st_q <= CRIE_ST_OK;
      rdata_q <= 8'h00;
      wake_irq_q <= 1'b0;
      err_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      en_q <= en_d;
      wake_f_q <= wake_f_d;
      csc_f_q <= csc_f_d;
      ovr_f_q <= ovr_f_d;
      rxf_f_q <= rxf_f_d;
      mask_q <= mask_d;
      rx_st_q <= rx_st_d;
      tx_st_q <= tx_st_d;
      rdata_q <= rdata_d;
      wake_irq_q <= wake_irq_d;
      err_irq_q <= err_irq_d;
      rx_irq_q <= rx_irq_d;
      irq_q <= irq_d;
    end
  end

  assign rdata_out    = rdata_q;
  assign wake_irq_out = wake_irq_q;
  assign err_irq_out  = err_irq_q;
  assign rx_irq_out   = rx_irq_q;
  assign irq_out      = irq_q;

  // ==========================================================
  // Assertions
  // Request outputs are registered from the same next values as the
  // flags and enables, so they must match the stored copies exactly.

  init_hold_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    init_mode |=> en_q[7:6] == 2'h0 && en_q[1:0] == 2'h0)
    else $error("enable not reset in init mode");

  init_write_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    wr_in && addr_in == `CRIE_OFF_ENABLE && !init_free && !init_mode
    |=> $stable(en_q))
    else $error("enable written during init");

  free_write_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    wr_in && addr_in == `CRIE_OFF_ENABLE && init_free
    |=> en_q == $past(wdata_in))
    else $error("enable write outside init lost");

  read_idle_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data without read strobe");

  sens_keep_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    init_mode |=> $stable(en_q[5:2]))
    else $error("sensitivity lost in init");

  wake_req_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    wake_irq_out == (wake_f_q && en_q[7]))
    else $error("wake request not flag and enable");

  wake_set_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    wake_event_in && en_q[7] && !wr_en && !init_mode |=> wake_irq_out)
    else $error("wake request missing");

  err_req_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    csc_f_q && en_q[6] |-> err_irq_out)
    else $error("status change request missing");

  rx_gate_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !csc_f_q && en_q[5:4] == 2'h0 && !tx_hit |=> !csc_f_q)
    else $error("receiver change flagged while off");

  tx_gate_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !csc_f_q && en_q[3:2] == 2'h0 && !rx_hit |=> !csc_f_q)
    else $error("transmitter change flagged while off");

  state_freeze_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    csc_f_q |=> $stable(rx_st_q) && $stable(tx_st_q))
    else $error("state changed while flag pending");

  ovr_req_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    overrun_event_in && en_q[1] && !wr_en && !init_mode |=> err_irq_out)
    else $error("overrun request missing");

  rxf_req_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    rx_load_in && en_q[0] && !wr_en && !init_mode |=> rx_irq_out)
    else $error("receive request missing");

  rx_busoff_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    tx_st_q == CRIE_ST_BUSOFF |-> rx_st_q == CRIE_ST_BUSOFF)
    else $error("receiver does not mirror bus-off");

  csc_set_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !csc_f_q && (rx_hit || tx_hit) |=> csc_f_q)
    else $error("status change flag not set");

  rx_warn_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !csc_f_q && tx_now != CRIE_ST_BUSOFF
    && {1'b0, rx_err_cnt_in} > `CRIE_WARN_LIMIT
    && {1'b0, rx_err_cnt_in} <= `CRIE_PASS_LIMIT
    |=> rx_st_q == CRIE_ST_WARNING)
    else $error("receiver warning state wrong");

  rxf_set_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    rx_load_in |=> rxf_f_q)
    else $error("receive full flag not set");

  err_level_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    err_irq_out == ((csc_f_q && en_q[6]) || (ovr_f_q && en_q[1])))
    else $error("error request not flag and enable");

  rx_level_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    rx_irq_out == (rxf_f_q && en_q[0]))
    else $error("receive request not flag and enable");

  irq_mask_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    irq_out == |({wake_f_q, csc_f_q, ovr_f_q, rxf_f_q} & mask_q))
    else $error("combined request not masked flags");
endmodule
`default_nettype wire

// ===== testbench/crie_top_tb_top.sv
// Self-checking bench for the receiver interrupt enable block
`timescale 1ns/1ps
`default_nettype none
`include "crie_map.svh"
module crie_top_tb_top;
  import crie_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       irq_rq = 1'b0;
  logic       irq_ak = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [7:0] rx_cnt = 8'h00;
  logic [8:0] tx_cnt = 9'h000;
  logic [7:0] rdata;
  logic [3:0] irqs;
  int         fail_count = 0;
  int         n_checks = 0;
  // Event table: enable bit, event pulse {wake,ovr,load,release}, expected requests {wake,err,rx,combined}
  logic [7:0] en_t [3] = '{8'h80, 8'h02, 8'h01};
  logic [3:0] ev_t [3] = '{4'h8, 4'h4, 4'h2};
  logic [3:0] iv_t [3] = '{4'h9, 4'h5, 4'h3};

  always #2.5 clk = ~clk;

  crie_top crie_top_inst (
    .core_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .init_request_in(irq_rq), .init_acknowledge_in(irq_ak),
    .wake_event_in(ev[3]), .overrun_event_in(ev[2]),
    .rx_load_in(ev[1]), .rx_release_in(ev[0]),
    .rx_err_cnt_in(rx_cnt), .tx_err_cnt_in(tx_cnt),
    .wake_irq_out(irqs[3]), .err_irq_out(irqs[2]),
    .rx_irq_out(irqs[1]), .irq_out(irqs[0]));

  // ==================================================
  // Access and compare tasks
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Strobe drops before the next call so no signal is set twice per step
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata, exp);
    @(posedge clk);
  endtask
  task automatic irq_chk(input logic [3:0] exp);
    #1 cmp({4'h0, irqs}, {4'h0, exp});
  endtask
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    wait_n(2);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==================================================
  // Main sequence
  initial begin
    wait_n(20);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`CRIE_OFF_ENABLE, `CRIE_ENABLE_RST);
    wr_reg(`CRIE_OFF_ENABLE, 8'hFF);
    rd_chk(`CRIE_OFF_ENABLE, 8'hFF);
    irq_rq <= 1'b1;
    irq_ak <= 1'b1;
    wait_n(2);
    rd_chk(`CRIE_OFF_ENABLE, 8'h3C);
    wr_reg(`CRIE_OFF_ENABLE, 8'hC3);
    rd_chk(`CRIE_OFF_ENABLE, 8'h3C);
    irq_rq <= 1'b0;
    irq_ak <= 1'b0;
    $display("test init_mode done");
    // Mask bit high lets the source through to the combined output
    wr_reg(`CRIE_OFF_IRQMASK, 8'h0F);
    for (int i = 0; i < 3; i++) begin
      for (int on = 0; on < 2; on++) begin
        wr_reg(`CRIE_OFF_ENABLE, (on != 0) ? en_t[i] : 8'h00);
        pulse(ev_t[i]);
        // Flag still reaches the combined output through the open mask
        irq_chk((on != 0) ? iv_t[i] : 4'h1);
        rd_chk(`CRIE_OFF_FLAGS, en_t[i]);
        wr_reg(`CRIE_OFF_FLAGS, en_t[i]);
        irq_chk(4'h0);
      end
    end
    wr_reg(`CRIE_OFF_ENABLE, 8'h01);
    wr_reg(`CRIE_OFF_IRQMASK, 8'h0E);
    pulse(4'h2);
    irq_chk(4'h2);
    pulse(4'h1);
    irq_chk(4'h0);
    rd_chk(4'h7, 8'h00);
    $display("test events done");
    wr_reg(`CRIE_OFF_IRQMASK, 8'h0F);
    wr_reg(`CRIE_OFF_ENABLE, 8'h70);
    rx_cnt <= 8'd96;
    wait_n(4);
    irq_chk(4'h0);
    rx_cnt <= 8'd97;
    wait_n(4);
    irq_chk(4'h5);
    rd_chk(`CRIE_OFF_STATUS, 8'h10);
    rx_cnt <= 8'd128;
    wait_n(4);
    rd_chk(`CRIE_OFF_STATUS, 8'h10);
    wr_reg(`CRIE_OFF_FLAGS, 8'h40);
    wait_n(3);
    rd_chk(`CRIE_OFF_STATUS, 8'h20);
    wr_reg(`CRIE_OFF_ENABLE, 8'h50);
    wr_reg(`CRIE_OFF_FLAGS, 8'h40);
    rx_cnt <= 8'd0;
    wait_n(4);
    irq_chk(4'h0);
    $display("test rx_state done");
    wr_reg(`CRIE_OFF_ENABLE, 8'h44);
    tx_cnt <= 9'd256;
    wait_n(4);
    irq_chk(4'h5);
    rd_chk(`CRIE_OFF_STATUS, 8'h3C);
    wr_reg(`CRIE_OFF_FLAGS, 8'h40);
    tx_cnt <= 9'd0;
    wait_n(4);
    irq_chk(4'h5);
    rd_chk(`CRIE_OFF_STATUS, 8'h00);
    $display("test tx_state done");
    end_sim();
  end
endmodule
`default_nettype wire
